// File: design/ocx_pkg.sv
// package: register map, field positions, reset values, timing and state codes
`default_nettype none
package ocx_pkg;
	// register byte addresses
	localparam logic [7:0] OCX_CTRL_OFS = 8'h1c;
	localparam logic [7:0] OCX_EN_OFS = 8'h20;
	localparam logic [7:0] OCX_PT1_OFS = 8'h24;
	localparam logic [7:0] OCX_PT2_OFS = 8'h28;
	localparam logic [7:0] OCX_POS_OFS = 8'h2c;
	localparam logic [7:0] OCX_STAT_OFS = 8'h30;
	// oscillation_control_byte fields
	localparam int OCX_REV_BIT = 0;
	localparam int OCX_SEL_BIT = 3;
	localparam int OCX_ALT_BIT = 4;
	localparam int OCX_NXT_BIT = 5;
	localparam int OCX_RAMP_BIT = 6;
	localparam int OCX_EXT_BIT = 7;
	// status register fields
	localparam int OCX_HALT_BIT = 0;
	localparam int OCX_DECEL_BIT = 2;
	localparam int OCX_ACT_BIT = 7;
	// reset values
	localparam logic [7:0] OCX_CTRL_RST = 8'h00;
	localparam logic [15:0] OCX_PT1_RST = 16'h0000;
	localparam logic [15:0] OCX_PT2_RST = 16'h0100;
	localparam logic [15:0] OCX_POS_RST = 16'h0000;
	// interface cycle timing
	localparam int OCX_CLK_MHZ = 20;
	localparam int OCX_CYCLE_US = 1000;
	localparam int OCX_CYCLE_CLKS = OCX_CYCLE_US * OCX_CLK_MHZ;
	// motion: top speed in position units per interface cycle, jog step
	localparam logic [3:0] OCX_VMAX = 4'h8;
	localparam logic [15:0] OCX_JOG_STEP = 16'h0001;
	typedef logic [15:0] ocx_pos_t;
	typedef enum logic [4:0] {
		OCX_IDLE = 5'b00001,
		OCX_RUN = 5'b00010,
		OCX_REV_DECEL = 5'b00100,
		OCX_RAMP = 5'b01000,
		OCX_HALT = 5'b10000
	} ocx_state_e;
endpackage : ocx_pkg
`default_nettype wire

// File: design/ocx_ctl_if.sv
// interface: register file to motion core
`default_nettype none
interface ocx_ctl_if;
	import ocx_pkg::*;
	logic [7:0] ctrl;
	logic enable;
	logic [1:0] pt_wr;
	ocx_pos_t pt_wdata;
	ocx_pos_t pt1;
	ocx_pos_t pt2;
	ocx_pos_t pos;
	logic rev_decel;
	logic osc_active;
	logic halted;
	modport regs (
		output ctrl,
		output enable,
		output pt_wr,
		output pt_wdata,
		input pt1,
		input pt2,
		input pos,
		input rev_decel,
		input osc_active,
		input halted
	);
	modport core (
		input ctrl,
		input enable,
		input pt_wr,
		input pt_wdata,
		output pt1,
		output pt2,
		output pos,
		output rev_decel,
		output osc_active,
		output halted
	);
endinterface : ocx_ctl_if
`default_nettype wire

// File: design/ocx_cycle_sampler.sv
// interface cycle tick, once-per-cycle sampling of the control byte, reversal edge
`default_nettype none
module ocx_cycle_sampler
	import ocx_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = OCX_CYCLE_CLKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [7:0] ctrl_raw,
	output logic tick,
	output logic [7:0] ctrl_smp,
	output logic rev_edge
);
	localparam int CW = $clog2(CYCLE_CLKS + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
		logic [7:0] smp;
		logic edge_p;
	} ocx_smp_s;
	ocx_smp_s s_q;
	ocx_smp_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.edge_p = 1'b0;
		if (s_q.cnt == CW'(CYCLE_CLKS - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
			s_d.smp = ctrl_raw;
			s_d.edge_p = ctrl_raw[OCX_REV_BIT] & ~s_q.smp[OCX_REV_BIT];
		end else begin
			s_d.cnt = s_q.cnt + CW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{cnt: '0, tick: 1'b0, smp: OCX_CTRL_RST, edge_p: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
	assign ctrl_smp = s_q.smp;
	assign rev_edge = s_q.edge_p;
endmodule : ocx_cycle_sampler
`default_nettype wire

// File: design/ocx_ahb_regs.sv
// AHB-Lite slave holding the control byte, enable and point write strobes
`default_nettype none
module ocx_ahb_regs
	import ocx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	ocx_ctl_if.regs ctl
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic en;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] rdata;
		logic [1:0] pt_wr;
		ocx_pos_t pt_wdata;
	} ocx_reg_s;
	ocx_reg_s r_q;
	ocx_reg_s r_d;
	logic [31:0] rmux;
	logic [31:0] stat;
	logic take;

	always_comb begin
		stat = '0;
		stat[OCX_HALT_BIT] = ctl.halted;
		stat[OCX_DECEL_BIT] = ctl.rev_decel;
		stat[OCX_ACT_BIT] = ctl.osc_active;
		unique case (haddr[7:0])
			OCX_CTRL_OFS: rmux = {24'h000000, r_q.ctrl};
			OCX_EN_OFS: rmux = {31'h00000000, r_q.en};
			OCX_PT1_OFS: rmux = {16'h0000, ctl.pt1};
			OCX_PT2_OFS: rmux = {16'h0000, ctl.pt2};
			OCX_POS_OFS: rmux = {16'h0000, ctl.pos};
			OCX_STAT_OFS: rmux = stat;
			default: rmux = '0;
		endcase
	end

	// only whole-word transfers are supported; hsize is not decoded
	assign take = hsel & hready & htrans[1];

	always_comb begin
		r_d = r_q;
		r_d.pt_wr = 2'b00;
		r_d.wr_pend = take & hwrite;
		if (take) begin
			r_d.waddr = haddr[7:0];
			if (!hwrite) begin
				r_d.rdata = rmux;
			end
		end
		if (r_q.wr_pend) begin
			r_d.pt_wdata = hwdata[15:0];
			unique case (r_q.waddr)
				OCX_CTRL_OFS: r_d.ctrl = hwdata[7:0];
				OCX_EN_OFS: r_d.en = hwdata[0];
				OCX_PT1_OFS: r_d.pt_wr = 2'b01;
				OCX_PT2_OFS: r_d.pt_wr = 2'b10;
				default: r_d.pt_wr = 2'b00;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_q <= '{ctrl: OCX_CTRL_RST, en: 1'b0, wr_pend: 1'b0, waddr: 8'h00,
				rdata: 32'h00000000, pt_wr: 2'b00, pt_wdata: OCX_POS_RST};
		end else begin
			r_q <= r_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_q.rdata;
	assign ctl.ctrl = r_q.ctrl;
	assign ctl.enable = r_q.en;
	assign ctl.pt_wr = r_q.pt_wr;
	assign ctl.pt_wdata = r_q.pt_wdata;
endmodule : ocx_ahb_regs
`default_nettype wire

// File: design/ocx_osc_axis.sv
// oscillating axis motion core with its control inputs and register access
`default_nettype none
module ocx_osc_axis
	import ocx_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = OCX_CYCLE_CLKS,
	parameter logic [3:0] VMAX = OCX_VMAX
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic axis_decel_request,
	input wire logic jog_plus,
	input wire logic jog_minus,
	output logic [15:0] axis_position,
	output logic reversal_decel_active,
	output logic oscillation_active_flag,
	output logic osc_halted
);
	ocx_ctl_if ctl ();

	logic tick;
	logic [7:0] c;
	logic rev_edge;

	ocx_ahb_regs u_regs (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.ctl(ctl.regs)
	);

	ocx_cycle_sampler #(
		.CYCLE_CLKS(CYCLE_CLKS)
	) u_smp (
		.hclk(hclk),
		.hresetn(hresetn),
		.ctrl_raw(ctl.ctrl),
		.tick(tick),
		.ctrl_smp(c),
		.rev_edge(rev_edge)
	);

	typedef struct packed {
		ocx_state_e st;
		logic dir;
		logic [3:0] v;
		ocx_pos_t pos;
		ocx_pos_t pt1;
		ocx_pos_t pt2;
	} ocx_core_s;
	ocx_core_s s_q;
	ocx_core_s s_d;

	ocx_pos_t tgt;
	ocx_pos_t sel_pt;
	ocx_pos_t jog_pt;
	ocx_pos_t step_pos;
	logic reached;
	logic decel_in;
	logic [16:0] up_sum;
	logic [16:0] dn_lim;

	// the point the axis heads for: point 2 when dir is set
	assign tgt = s_q.dir ? s_q.pt2 : s_q.pt1;
	assign sel_pt = c[OCX_SEL_BIT] ? s_q.pt2 : s_q.pt1;
	// outside deceleration only counts while the axis is not externally controlled
	assign decel_in = c[OCX_RAMP_BIT] | (~c[OCX_EXT_BIT] & axis_decel_request);

	// one step of v units toward the target, clamped onto it
	always_comb begin
		up_sum = {1'b0, s_q.pos} + {13'h0000, s_q.v};
		dn_lim = {1'b0, tgt} + {13'h0000, s_q.v};
		if (tgt >= s_q.pos) begin
			reached = up_sum >= {1'b0, tgt};
			step_pos = reached ? tgt : up_sum[15:0];
		end else begin
			reached = dn_lim >= {1'b0, s_q.pos};
			step_pos = reached ? tgt : s_q.pos - {12'h000, s_q.v};
		end
	end

	// jog moves the selected point by one step per interface cycle
	always_comb begin
		jog_pt = sel_pt;
		if (jog_plus & ~jog_minus) begin
			jog_pt = sel_pt + OCX_JOG_STEP;
		end else if (jog_minus & ~jog_plus) begin
			jog_pt = sel_pt - OCX_JOG_STEP;
		end
	end

	always_comb begin
		s_d = s_q;
		// software point writes; a hardware update in the same cycle overrides below
		if (ctl.pt_wr[0]) begin
			s_d.pt1 = ctl.pt_wdata;
		end
		if (ctl.pt_wr[1]) begin
			s_d.pt2 = ctl.pt_wdata;
		end
		if (!ctl.enable) begin
			s_d.st = OCX_IDLE;
			s_d.v = 4'h0;
		end else if (tick) begin
			if (c[OCX_ALT_BIT]) begin
				if (c[OCX_SEL_BIT]) begin
					s_d.pt2 = jog_pt;
				end else begin
					s_d.pt1 = jog_pt;
				end
			end
			// with alter low the points are left alone by jog
			unique case (s_q.st)
				OCX_IDLE: begin
					s_d.st = OCX_RUN;
				end
				OCX_RUN: begin
					if (decel_in) begin
						s_d.st = OCX_RAMP;
					end else if (rev_edge) begin
						s_d.st = OCX_REV_DECEL;
					end else begin
						// uninterrupted travel
						if (s_q.v < VMAX) begin
							s_d.v = s_q.v + 4'h1;
						end
						s_d.pos = step_pos;
						if (reached) begin
							if (c[OCX_NXT_BIT]) begin
								s_d.st = OCX_HALT;
								s_d.v = 4'h0;
							end else begin
								s_d.dir = ~s_q.dir;
							end
						end
					end
				end
				OCX_REV_DECEL: begin
					if (s_q.v == 4'h0) begin
						if (c[OCX_ALT_BIT]) begin
							if (c[OCX_SEL_BIT]) begin
								s_d.pt2 = s_q.pos;
							end else begin
								s_d.pt1 = s_q.pos;
							end
						end
						// alter low: stored points untouched
						s_d.dir = ~s_q.dir;
						s_d.st = OCX_RUN;
					end else begin
						s_d.v = s_q.v - 4'h1;
						s_d.pos = step_pos;
					end
				end
				OCX_RAMP: begin
					if (s_q.v != 4'h0) begin
						s_d.v = s_q.v - 4'h1;
						s_d.pos = step_pos;
					end else if (!decel_in) begin
						s_d.st = OCX_RUN;
					end
				end
				OCX_HALT: begin
					s_d.st = OCX_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{st: OCX_IDLE, dir: 1'b1, v: 4'h0, pos: OCX_POS_RST,
				pt1: OCX_PT1_RST, pt2: OCX_PT2_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign ctl.pt1 = s_q.pt1;
	assign ctl.pt2 = s_q.pt2;
	assign ctl.pos = s_q.pos;
	assign ctl.rev_decel = (s_q.st == OCX_REV_DECEL);
	assign ctl.osc_active = (s_q.st == OCX_RUN) | (s_q.st == OCX_REV_DECEL)
		| (s_q.st == OCX_RAMP);
	assign ctl.halted = (s_q.st == OCX_HALT);
	assign axis_position = s_q.pos;
	assign reversal_decel_active = ctl.rev_decel;
	assign oscillation_active_flag = ctl.osc_active;
	assign osc_halted = ctl.halted;
endmodule : ocx_osc_axis
`default_nettype wire

// File: verification/ocx_osc_axis_checker.sv
// port assertions for the oscillating axis block
`default_nettype none
module ocx_osc_axis_checker
	import ocx_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = OCX_CYCLE_CLKS,
	parameter logic [3:0] VMAX = OCX_VMAX
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] axis_position,
	input wire logic reversal_decel_active,
	input wire logic oscillation_active_flag,
	input wire logic osc_halted
);
	logic [15:0] pos_q;
	logic [15:0] gap_q;
	logic act_q;
	logic [15:0] up;
	logic [15:0] dn;
	assign up = axis_position - pos_q;
	assign dn = pos_q - axis_position;
	// gap_q counts clocks since the position last moved
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_q <= 16'h0;
			gap_q <= 16'hffff;
			act_q <= 1'h0;
		end else begin
			pos_q <= axis_position;
			gap_q <= (up != 16'h0) ? 16'h0 : gap_q + 16'(gap_q != 16'hffff);
			act_q <= oscillation_active_flag;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_unmapped;
		s_rd_taken ##0 haddr[7:0] > 8'h30;
	endsequence
	a_ready_high: assert property (hreadyout == 1'h1)
		else $error("wait state seen");
	a_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
		else $error("read data moved");
	a_step_bound: assert property (up <= 16'(VMAX) || dn <= 16'(VMAX))
		else $error("step too large");
	a_step_tick: assert property (up != 16'h0 |-> gap_q >= CYCLE_CLKS - 1)
		else $error("step between ticks");
	a_decel_active: assert property (reversal_decel_active |-> oscillation_active_flag)
		else $error("braking while inactive");
	a_halt_idle: assert property (osc_halted |-> !oscillation_active_flag)
		else $error("halted yet active");
	a_idle_still: assert property (!oscillation_active_flag && !act_q |-> up == 16'h0)
		else $error("moving while inactive");
endmodule : ocx_osc_axis_checker
bind ocx_osc_axis ocx_osc_axis_checker #(.CYCLE_CLKS(CYCLE_CLKS), .VMAX(VMAX)) chk_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.axis_position(axis_position), .reversal_decel_active(reversal_decel_active),
	.oscillation_active_flag(oscillation_active_flag), .osc_halted(osc_halted)
);
`default_nettype wire

// File: verification/ocx_plc_model.sv
// controller-side bus master issuing single word transfers
`default_nettype none
module ocx_plc_model (
	input wire logic hclk,
	input wire logic hready,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// address phase, then data phase, each held until hready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hready !== 1'h1);
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : ocx_plc_model
`default_nettype wire

// File: verification/ocx_osc_axis_tb.sv
// self-checking bench for the oscillating axis block
`default_nettype none
module ocx_osc_axis_tb;
	import ocx_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int C = 8;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic rd_ph = 1'h0;
	logic dec_rq = 1'h0;
	logic jog_p = 1'h0;
	logic jog_m = 1'h0;
	logic hsel, hwrite, hreadyout, rev, act, halt;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rs, p1, e, m;
	logic [15:0] pos, p;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	int bad_count = 0;
	int checks = 0;
	int i;
	always #25 hclk = ~hclk;
	ocx_osc_axis #(.CYCLE_CLKS(C)) ocx_osc_axis_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .axis_decel_request(dec_rq),
		.jog_plus(jog_p), .jog_minus(jog_m), .axis_position(pos),
		.reversal_decel_active(rev), .oscillation_active_flag(act), .osc_halted(halt)
	);
	ocx_plc_model plc_inst (
		.hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
	);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		plc_inst.xfer(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k = '1);
		eq.push_back(x);
		mq.push_back(k);
		plc_inst.xfer(1'h0, a, 32'h0);
	endtask : rd
	task automatic tk(input int n);
		repeat (n * C) @(posedge hclk);
	endtask : tk
	task automatic complete_run();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	// read data is compared at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_ph) begin
			e = eq.pop_front();
			m = mq.pop_front();
			checks++;
			if ((hrdata & m) !== (e & m)) begin
				bad_count++;
				$display("wrong value at %0t: read %h expected %h", $time, hrdata, e);
			end
		end
		rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		complete_run();
	end
	initial begin
		rs = 32'h00012e4d;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(OCX_CTRL_OFS, {24'h0, OCX_CTRL_RST});
		rd(OCX_EN_OFS, 32'h0);
		rd(OCX_PT1_OFS, {16'h0, OCX_PT1_RST});
		rd(OCX_PT2_OFS, {16'h0, OCX_PT2_RST});
		rd(OCX_POS_OFS, {16'h0, OCX_POS_RST});
		rd(OCX_STAT_OFS, 32'h0);
		rd(8'h40, 32'h0);
		rs = nx(rs);
		p1 = {27'h0, rs[12:8]};
		wr(OCX_CTRL_OFS, {24'h0, rs[7:0]});
		wr(OCX_PT1_OFS, p1);
		rd(OCX_CTRL_OFS, {24'h0, rs[7:0]});
		wr(OCX_CTRL_OFS, 32'h0);
		wr(OCX_EN_OFS, 32'h1);
		rd(OCX_PT1_OFS, p1);
		wr(OCX_CTRL_OFS, 32'h18);
		jog_p <= 1'h1;
		tk(5);
		jog_p <= 1'h0;
		tk(2);
		wr(OCX_CTRL_OFS, 32'h0);
		jog_m <= 1'h1;
		tk(3);
		jog_m <= 1'h0;
		tk(2);
		rd(OCX_PT2_OFS, {16'h0, OCX_PT2_RST + 16'h5 * OCX_JOG_STEP});
		rd(OCX_PT1_OFS, p1);
		wr(OCX_CTRL_OFS, 32'h19);
		for (i = 0; i < 400 && !rev; i++) @(posedge hclk) #1;
		rd(OCX_STAT_OFS, 32'h84, 32'h85);
		wr(OCX_CTRL_OFS, 32'h18);
		for (i = 0; i < 400 && rev; i++) @(posedge hclk) #1;
		p = pos;
		tk(1);
		rd(OCX_PT2_OFS, {16'h0, p});
		tk(40);
		rd(OCX_STAT_OFS, 32'h80, 32'h81);
		wr(OCX_CTRL_OFS, 32'h01);
		for (i = 0; i < 400 && !rev; i++) @(posedge hclk) #1;
		wr(OCX_CTRL_OFS, 32'h0);
		for (i = 0; i < 400 && rev; i++) @(posedge hclk) #1;
		rd(OCX_PT1_OFS, p1);
		rd(OCX_PT2_OFS, {16'h0, p});
		wr(OCX_CTRL_OFS, 32'h20);
		for (i = 0; i < 900 && !halt; i++) @(posedge hclk) #1;
		rd(OCX_STAT_OFS, 32'h01, 32'h85);
		wr(OCX_EN_OFS, 32'h0);
		wr(OCX_EN_OFS, 32'h1);
		wr(OCX_CTRL_OFS, 32'h80);
		tk(1);
		dec_rq <= 1'h1;
		tk(4);
		#1 p = pos;
		rd(OCX_STAT_OFS, 32'h80, 32'h81);
		tk(2);
		#1;
		checks++;
		if (pos === p) begin
			bad_count++;
			$display("wrong value at %0t: axis stopped under external control", $time);
		end
		wr(OCX_CTRL_OFS, 32'h0);
		// ramping keeps the active flag; the stop shows as a frozen position
		tk(12);
		#1 p = pos;
		tk(2);
		rd(OCX_POS_OFS, {16'h0, p});
		rd(OCX_STAT_OFS, 32'h80, 32'h85);
		dec_rq <= 1'h0;
		wr(OCX_EN_OFS, 32'h0);
		wr(OCX_EN_OFS, 32'h1);
		tk(3);
		rd(OCX_STAT_OFS, 32'h80, 32'h80);
		wr(OCX_CTRL_OFS, 32'h40);
		tk(12);
		#1 p = pos;
		tk(2);
		rd(OCX_POS_OFS, {16'h0, p});
		rd(OCX_STAT_OFS, 32'h80, 32'h85);
		wr(OCX_EN_OFS, 32'h0);
		tk(1);
		complete_run();
	end
endmodule : ocx_osc_axis_tb
`default_nettype wire
